// File: core/dmra_defines.vh
//Contract
// - Four pages of four 8-bit special registers exist.
// - Mode set commands enable the mode and pick the page; enable is bit 2.
// - In the mode every read is served from the selected special register; the core drops a read that arrives before the previous burst has ended.
// - Auto precharge on reads and writes is ignored in the mode.
// - Mode registers are returned as upper and lower halves.
// - Page 0 powers up as 55, 33, 0F, 00 in register order.
// - Only page 0 is writable; written values hold until reset.
// - Page 1 returns the logged parity and CRC error frame when parity is on.
// - Page 2 returns mode register contents; page 3 is reserved.
// - Page 0 reads serial, parallel or staggered; other pages serial only.
// - Serial readout drives the same bit sequence on every lane.
// - Parallel readout repeats location 0 in every UI; other locations forbidden.
`ifndef DMRA_DEFINES_VH
`define DMRA_DEFINES_VH
`define DMRA_MR_W 14
`define DMRA_MR_SPR 3
`define DMRA_MR_BL 0
`define DMRA_MR_PAR 5
`define DMRA_SPR_EN_BIT 2
`define DMRA_PAGE_LSB 0
`define DMRA_FMT_LSB 11
`define DMRA_FGR_LSB 6
`define DMRA_DBI_RD_BIT 12
`define DMRA_AP_BIT 10
`define DMRA_FMT_SERIAL 2'h0
`define DMRA_FMT_PARALLEL 2'h1
`define DMRA_FMT_STAGGER 2'h2
`define DMRA_BL_BC4 2'h2
`define DMRA_TP0_RST 8'h55
`define DMRA_TP1_RST 8'h33
`define DMRA_TP2_RST 8'h0F
`define DMRA_TP3_RST 8'h00
`define DMRA_CMD_ACT 3'h1
`define DMRA_CMD_PRE 3'h2
`define DMRA_CMD_REF 3'h3
`define DMRA_CMD_RD 3'h4
`define DMRA_CMD_WR 3'h5
`define DMRA_ERR_CMD 0
`define DMRA_ERR_PWR 1
`define DMRA_ERR_REFRATE 2
`define DMRA_ERR_TRFC 3
`define DMRA_ERR_REFBUSY 4
`define DMRA_ERR_DBI 5
`define DMRA_ERR_OPEN 6
`define DMRA_ERR_RDADDR 7
`define DMRA_T_RFC_NS 260
`define DMRA_CLK_NS 10
`define DMRA_T_RFC_CYC ((`DMRA_T_RFC_NS + `DMRA_CLK_NS - 1) / `DMRA_CLK_NS)
`endif

// File: core/dmra_sync.v
`timescale 1ns/100ps
module dmra_sync #(
  parameter WIDTH = 1
) (
  input wire clk,
  input wire srst,
  input wire [WIDTH-1:0] d,
  output reg [WIDTH-1:0] q
);
  reg [WIDTH-1:0] meta;

  always @(posedge clk) begin
    if (srst) begin
      meta <= {WIDTH{1'b0}};
      q <= {WIDTH{1'b0}};
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule // dmra_sync

// File: core/dmra_page0_mem.v
`timescale 1ns/100ps
`include "dmra_defines.vh"
module dmra_page0_mem (
  input wire clk,
  input wire srst,
  input wire we,
  input wire [1:0] waddr,
  input wire [7:0] wdata,
  output reg [31:0] q
);
  // Reset doubles as re-initialisation of the training patterns
  always @(posedge clk) begin
    if (srst) begin
      q <= {`DMRA_TP3_RST, `DMRA_TP2_RST, `DMRA_TP1_RST, `DMRA_TP0_RST};
    end else if (we) begin
      case (waddr)
        2'h0: q[7:0] <= wdata;
        2'h1: q[15:8] <= wdata;
        2'h2: q[23:16] <= wdata;
        default: q[31:24] <= wdata;
      endcase
    end
  end
endmodule // dmra_page0_mem

// File: core/dmra_core.v
`timescale 1ns/100ps
`include "dmra_defines.vh"
module dmra_core #(
  parameter DQW = 16,
  parameter READ_LAT = 4,
  parameter TRFC_CYC = `DMRA_T_RFC_CYC
) (
  input wire clk,
  input wire srst,
  input wire ck,
  input wire cke,
  input wire cs_n,
  input wire act_n,
  input wire ras_n,
  input wire cas_n,
  input wire we_n,
  input wire [1:0] bg,
  input wire [1:0] ba,
  input wire [17:0] addr,
  input wire [31:0] err_frame,
  output wire [DQW-1:0] dq_in_unused_n,
  output reg [DQW-1:0] dq_out,
  output reg dq_oe,
  output reg array_cmd_valid,
  output reg [2:0] array_cmd,
  output reg [3:0] array_bank,
  output reg [17:0] array_addr,
  output reg array_ap,
  output wire spr_mode,
  output wire [1:0] spr_page,
  output reg [7:0] proto_err
);
  localparam ST_IDLE = 3'b001;
  localparam ST_WAIT = 3'b010;
  localparam ST_BURST = 3'b100;

  // Byte of a page at a location; page 2 splits a mode register in halves
  // four four-byte pages
  function [7:0] page_byte;
    input [1:0] page;
    input [1:0] loc;
    input [31:0] p0;
    input [31:0] p1;
    input [`DMRA_MR_W-1:0] mrv;
    reg [31:0] src;
    begin
      src = 32'h0000_0000;
      case (page)
        2'h0: src = p0;
        2'h1: src = p1;
        2'h2: src = {16'h0000, 2'h0, mrv[13:8], mrv[7:0]};
        default: src = 32'h0000_0000;
      endcase
      case (loc)
        2'h0: page_byte = src[7:0];
        2'h1: page_byte = src[15:8];
        2'h2: page_byte = src[23:16];
        default: page_byte = src[31:24];
      endcase
    end
  endfunction

  wire [28:0] pin_s;
  wire ck_s;
  wire cke_s;
  wire cs_n_s;
  wire act_n_s;
  wire [2:0] rcw_s;
  wire [1:0] bg_s;
  wire [1:0] ba_s;
  wire [17:0] addr_s;

  dmra_sync #(.WIDTH(29)) u_pin_sync (
    .clk(clk),
    .srst(srst),
    .d({ck, cke, cs_n, act_n, ras_n, cas_n, we_n, bg, ba, addr}),
    .q(pin_s)
  );

  assign ck_s = pin_s[28];
  assign cke_s = pin_s[27];
  assign cs_n_s = pin_s[26];
  assign act_n_s = pin_s[25];
  assign rcw_s = pin_s[24:22];
  assign bg_s = pin_s[21:20];
  assign ba_s = pin_s[19:18];
  assign addr_s = pin_s[17:0];
  assign dq_in_unused_n = {DQW{1'b0}};

  reg ck_d;
  wire ck_rise;
  always @(posedge clk) begin
    if (srst) begin
      ck_d <= 1'b0;
    end else begin
      ck_d <= ck_s;
    end
  end
  assign ck_rise = ck_s & ~ck_d;

  wire sel = ck_rise & ~cs_n_s;
  wire is_act = sel & ~act_n_s;
  wire is_oth = sel & act_n_s;
  wire is_mrs = is_oth & (rcw_s == 3'b000);
  wire is_ref = is_oth & (rcw_s == 3'b001);
  wire is_pre = is_oth & (rcw_s == 3'b010);
  wire is_wr = is_oth & (rcw_s == 3'b100);
  wire is_rd = is_oth & (rcw_s == 3'b101);
  wire is_zq = is_oth & (rcw_s == 3'b110);

  reg [`DMRA_MR_W-1:0] mr [0:7];
  wire [2:0] mr_idx = {bg_s[0], ba_s};
  integer k;

  // mode set commands load mode registers
  always @(posedge clk) begin
    if (srst) begin
      for (k = 0; k < 8; k = k + 1) begin
        mr[k] <= {`DMRA_MR_W{1'b0}};
      end
    end else if (is_mrs) begin
      mr[mr_idx] <= addr_s[`DMRA_MR_W-1:0];
    end
  end

  wire [`DMRA_MR_W-1:0] mr_spr = mr[`DMRA_MR_SPR];
  assign spr_mode = mr_spr[`DMRA_SPR_EN_BIT];
  assign spr_page = mr_spr[`DMRA_PAGE_LSB+1:`DMRA_PAGE_LSB];
  wire [1:0] spr_fmt = mr_spr[`DMRA_FMT_LSB+1:`DMRA_FMT_LSB];
  wire [2:0] fgr_mode = mr_spr[`DMRA_FGR_LSB+2:`DMRA_FGR_LSB];
  wire [`DMRA_MR_W-1:0] mr_par = mr[`DMRA_MR_PAR];
  wire par_on = |mr_par[2:0];
  wire dbi_rd_on = mr_par[`DMRA_DBI_RD_BIT];
  wire [`DMRA_MR_W-1:0] mr_bl = mr[`DMRA_MR_BL];

  wire [31:0] p0_q;
  // writes land on page 0 only
  wire p0_we = is_wr & spr_mode & (spr_page == 2'h0);

  dmra_page0_mem u_page0 (
    .clk(clk),
    .srst(srst),
    .we(p0_we),
    .waddr(ba_s),
    .wdata(addr_s[7:0]),
    .q(p0_q)
  );

  // error frame only while parity checking is on
  wire [31:0] p1_q = par_on ? err_frame : 32'h0000_0000;

  reg [2:0] state;
  reg [1:0] rd_page;
  reg [1:0] rd_loc;
  reg [1:0] rd_fmt;
  reg [2:0] rd_mrsel;
  reg rd_bc4;
  reg [7:0] lat_cnt;
  reg [2:0] ui_cnt;
  wire [`DMRA_MR_W-1:0] rd_mrv = mr[rd_mrsel];
  wire [2:0] ui_last = rd_bc4 ? 3'h3 : 3'h7;
  wire [2:0] ui_next = (state == ST_WAIT) ? 3'h0 : ui_cnt + 3'h1;
  wire busy = (state != ST_IDLE);
  wire rd_spr = is_rd & spr_mode;

  reg [DQW-1:0] next_dq;
  reg [7:0] lane_byte;
  reg [2:0] lane_sum;
  reg [2:0] lane_bit;
  integer j;

  always @* begin
    next_dq = {DQW{1'b0}};
    lane_byte = 8'h00;
    lane_sum = 3'h0;
    lane_bit = 3'h0;
    for (j = 0; j < DQW; j = j + 1) begin
      lane_sum = {1'b0, rd_loc} + {1'b0, j[3:2]};
      lane_bit = j[2:0];
      case (rd_fmt)
        `DMRA_FMT_PARALLEL: next_dq[j] = p0_q[~lane_bit];
        `DMRA_FMT_STAGGER: begin
          lane_byte = page_byte(2'h0, lane_sum[1:0], p0_q, p1_q, rd_mrv);
          next_dq[j] = lane_byte[~ui_next];
        end
        default: begin
          lane_byte = page_byte(rd_page, rd_loc, p0_q, p1_q, rd_mrv);
          next_dq[j] = lane_byte[~ui_next];
        end
      endcase
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      state <= ST_IDLE;
      rd_page <= 2'h0;
      rd_loc <= 2'h0;
      rd_fmt <= `DMRA_FMT_SERIAL;
      rd_mrsel <= 3'h0;
      rd_bc4 <= 1'b0;
      lat_cnt <= 8'h00;
      ui_cnt <= 3'h0;
      dq_out <= {DQW{1'b0}};
      dq_oe <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (rd_spr) begin
            rd_page <= spr_page;
            rd_loc <= ba_s;
            // only page 0 honours non-serial formats
            rd_fmt <= (spr_page == 2'h0) ? spr_fmt : `DMRA_FMT_SERIAL;
            rd_mrsel <= addr_s[7:5];
            // fixed burst eight or chop four
            rd_bc4 <= (mr_bl[1:0] == `DMRA_BL_BC4);
            lat_cnt <= READ_LAT[7:0] - 8'h01;
            state <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (ck_rise) begin
            if (lat_cnt == 8'h00) begin
              ui_cnt <= 3'h0;
              dq_out <= next_dq;
              dq_oe <= 1'b1;
              state <= ST_BURST;
            end else begin
              lat_cnt <= lat_cnt - 8'h01;
            end
          end
        end
        ST_BURST: begin
          if (ck_rise) begin
            if (ui_cnt == ui_last) begin
              dq_out <= {DQW{1'b0}};
              dq_oe <= 1'b0;
              state <= ST_IDLE;
            end else begin
              ui_cnt <= ui_next;
              dq_out <= next_dq;
            end
          end
        end
        default: begin
          dq_oe <= 1'b0;
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // array path when the mode is off; refresh reaches the array in the mode too
  always @(posedge clk) begin
    if (srst) begin
      array_cmd_valid <= 1'b0;
      array_cmd <= 3'h0;
      array_bank <= 4'h0;
      array_addr <= 18'h00000;
      array_ap <= 1'b0;
    end else begin
      array_cmd_valid <= 1'b0;
      if (is_ref | (~spr_mode & (is_act | is_pre | is_rd | is_wr))) begin
        array_cmd_valid <= 1'b1;
        array_bank <= {bg_s, ba_s};
        array_addr <= addr_s;
        // auto precharge never reaches the array in the mode
        array_ap <= addr_s[`DMRA_AP_BIT] & ~spr_mode;
        if (is_act) begin
          array_cmd <= `DMRA_CMD_ACT;
        end else if (is_pre) begin
          array_cmd <= `DMRA_CMD_PRE;
        end else if (is_ref) begin
          array_cmd <= `DMRA_CMD_REF;
        end else if (is_rd) begin
          array_cmd <= `DMRA_CMD_RD;
        end else begin
          array_cmd <= `DMRA_CMD_WR;
        end
      end
    end
  end

  // Open-bank tracking and refresh window for misuse reporting
  reg [15:0] open_bank;
  reg [15:0] trfc_cnt;
  wire [15:0] bank_bit = 16'h0001 << {bg_s, ba_s};
  always @(posedge clk) begin
    if (srst) begin
      open_bank <= 16'h0000;
      trfc_cnt <= 16'h0000;
    end else begin
      if (is_act) begin
        open_bank <= open_bank | bank_bit;
      end else if (is_pre) begin
        open_bank <= addr_s[`DMRA_AP_BIT] ? 16'h0000 : (open_bank & ~bank_bit);
      end else if ((is_rd | is_wr) & ~spr_mode & addr_s[`DMRA_AP_BIT]) begin
        open_bank <= open_bank & ~bank_bit;
      end
      if (is_ref) begin
        trfc_cnt <= TRFC_CYC[15:0];
      end else if (trfc_cnt != 16'h0000) begin
        trfc_cnt <= trfc_cnt - 16'h0001;
      end
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      proto_err <= 8'h00;
    end else begin
      proto_err <= 8'h00;
      proto_err[`DMRA_ERR_CMD] <= spr_mode & (is_act | is_pre | is_zq);
      proto_err[`DMRA_ERR_PWR] <= spr_mode & ck_rise & ~cke_s;
      proto_err[`DMRA_ERR_REFRATE] <= spr_mode & is_ref & (fgr_mode != 3'h0);
      proto_err[`DMRA_ERR_TRFC] <= sel & ~is_ref & (trfc_cnt != 16'h0000);
      proto_err[`DMRA_ERR_REFBUSY] <= is_ref & busy;
      proto_err[`DMRA_ERR_DBI] <= rd_spr & dbi_rd_on;
      // banks idle before the mode change
      proto_err[`DMRA_ERR_OPEN] <= is_mrs & (mr_idx == 3'h3) & (open_bank != 16'h0000);
      proto_err[`DMRA_ERR_RDADDR] <= rd_spr & (((addr_s[2:0] != 3'h0) & (addr_s[2:0] != 3'h4))
        | ((spr_page == 2'h0) & (spr_fmt == `DMRA_FMT_PARALLEL) & (ba_s != 2'h0)));
    end
  end
endmodule // dmra_core

// File: bench/dmra_core_asserts.sv
`timescale 1ns/100ps
`include "dmra_defines.vh"
module dmra_core_asserts #(
  parameter DQW = 16
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic ck,
  input wire logic [DQW-1:0] dq_out,
  input wire logic dq_oe,
  input wire logic array_cmd_valid,
  input wire logic [2:0] array_cmd,
  input wire logic array_ap,
  input wire logic spr_mode,
  input wire logic [1:0] spr_page,
  input wire logic [7:0] proto_err
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  logic ck_d;
  logic [3:0] n_ck;
  // Counts link clock rises while the data bus is driven
  always @(posedge clk) begin
    ck_d <= ck;
    if (!dq_oe) n_ck <= 4'h0;
    else if (ck && !ck_d) n_ck <= n_ck + 4'h1;
  end
  ap_in_mode_a: assert property (array_cmd_valid && spr_mode |-> !array_ap)
    else $error("precharge forwarded in mode");
  no_array_rw_a: assert property (array_cmd_valid && spr_mode |->
    array_cmd != `DMRA_CMD_RD && array_cmd != `DMRA_CMD_WR)
    else $error("array access in mode");
  serial_lanes_a: assert property (dq_oe && spr_page != 2'h0 |-> dq_out == {DQW{dq_out[0]}})
    else $error("lanes differ in serial readout");
  burst_len_a: assert property ($fell(dq_oe) |-> n_ck == 4'h8 || n_ck == 4'h4)
    else $error("burst length wrong");
  ui_on_ck_a: assert property ($changed(dq_out) |-> $past(ck, 2))
    else $error("data changed away from link clock rise");
  cmd_pulse_a: assert property (array_cmd_valid |=> !array_cmd_valid)
    else $error("array command longer than one cycle");
  err_pulse_a: assert property (|proto_err |=> proto_err == 8'h00)
    else $error("error flag longer than one cycle");
  reset_clear_a: assert property ($fell(srst) |-> !dq_oe && !spr_mode && !array_cmd_valid)
    else $error("outputs not cleared by reset");
  cover property ($rose(dq_oe) && spr_page == 2'h2);
  cover property (|proto_err);
  cover property (array_cmd_valid && !spr_mode);
endmodule // dmra_core_asserts
bind dmra_core dmra_core_asserts #(.DQW(DQW)) u_asserts (.clk(clk), .srst(srst), .ck(ck), .dq_out(dq_out),
  .dq_oe(dq_oe), .array_cmd_valid(array_cmd_valid), .array_cmd(array_cmd), .array_ap(array_ap),
  .spr_mode(spr_mode), .spr_page(spr_page), .proto_err(proto_err));

// File: bench/dmra_ctrl_model.sv
`timescale 1ns/100ps
module dmra_ctrl_model (
  input wire logic clk,
  output logic ck,
  output logic cs_n,
  output logic act_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic [1:0] bg,
  output logic [1:0] ba,
  output logic [17:0] addr
);
  initial begin
    {cs_n, act_n, ras_n, cas_n, we_n, bg, ba, addr} = {5'h1F, 22'h0};
    ck = 1'b0;
    #3;
    forever #62.5 ck = ~ck;
  end
  // one command per ck cycle, deselected between
  task automatic cmd(input logic [3:0] c, input logic [3:0] bk, input logic [17:0] a);
    @(negedge ck);
    @(posedge clk);
    {cs_n, act_n, ras_n, cas_n, we_n} <= {1'b0, c};
    {bg, ba} <= bk;
    addr <= a;
    @(negedge ck);
    @(posedge clk);
    cs_n <= 1'b1;
    {act_n, ras_n, cas_n, we_n, bg, ba, addr} <= ~{c, bk, a};
  endtask
endmodule // dmra_ctrl_model

// File: bench/dmra_core_tb_top.sv
`timescale 1ns/100ps
module dmra_core_tb_top;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic cke = 1'b1;
  logic err_clr = 1'b0;
  logic [31:0] err_frame = 32'h1E2D3C4B;
  logic ck, cs_n, act_n, ras_n, cas_n, we_n, dq_oe, array_cmd_valid, array_ap, spr_mode;
  logic [1:0] bg, ba, spr_page;
  logic [17:0] addr;
  logic [15:0] dq_out;
  logic [2:0] array_cmd;
  logic [3:0] array_bank;
  logic [17:0] array_addr;
  logic [7:0] proto_err, err_seen;
  logic [7:0] pat [0:3];
  int bad_count = 0;
  int checks = 0;
  int cyc = 0;
  always #5 clk = ~clk;
  dmra_ctrl_model ctl (.clk(clk), .ck(ck), .cs_n(cs_n), .act_n(act_n), .ras_n(ras_n), .cas_n(cas_n),
    .we_n(we_n), .bg(bg), .ba(ba), .addr(addr));
  dmra_core #(.DQW(16), .READ_LAT(4), .TRFC_CYC(30)) DUT (.clk(clk), .srst(srst), .ck(ck), .cke(cke),
    .cs_n(cs_n), .act_n(act_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .bg(bg), .ba(ba), .addr(addr),
    .err_frame(err_frame), .dq_in_unused_n(), .dq_out(dq_out), .dq_oe(dq_oe),
    .array_cmd_valid(array_cmd_valid), .array_cmd(array_cmd), .array_bank(array_bank), .array_addr(array_addr),
    .array_ap(array_ap), .spr_mode(spr_mode), .spr_page(spr_page), .proto_err(proto_err));
  always @(posedge clk) err_seen <= (srst || err_clr) ? 8'h00 : err_seen | proto_err;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      finish_test();
    end
  end
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Expected lanes of one unit: serial, parallel or staggered
  function automatic logic [15:0] ui(input logic [1:0] f, input logic [1:0] l, input int u);
    logic [15:0] r;
    for (int j = 0; j < 16; j++)
      r[j] = (f == 2'h1) ? pat[0][7 - j % 8] : pat[(f == 2'h2) ? (l + j / 4) % 4 : l][7 - u];
    return r;
  endfunction
  task automatic mrs(input logic [2:0] i, input logic [13:0] v);
    ctl.cmd(4'h8, {1'b0, i}, {4'h0, v});
  endtask
  task automatic rd(input logic [1:0] l, input logic [17:0] a, input logic [1:0] f, input int n);
    int k;
    ctl.cmd(4'hD, {2'h0, l}, a);
    k = 0;
    while (dq_oe !== 1'b1 && k < 200) begin
      @(negedge clk);
      k++;
    end
    for (int u = 0; u <= n; u++) begin
      if (u > 0) begin
        @(posedge ck);
        repeat (5) @(negedge clk);
      end
      if (u < n) chk(dq_out, ui(f, l, u));
      else chk(dq_oe, 1'b0);
    end
  endtask
  task automatic clr_err;
    @(posedge clk) err_clr <= 1'b1;
    @(posedge clk) err_clr <= 1'b0;
  endtask
  task automatic bad(input logic [3:0] c, input logic [3:0] bk, input logic [17:0] a, input logic [7:0] e);
    clr_err();
    ctl.cmd(c, bk, a);
    repeat (16) @(posedge ck);
    @(negedge clk);
    chk(err_seen, e);
  endtask
  initial begin
    pat = '{8'h55, 8'h33, 8'h0F, 8'h00};
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    repeat (3) @(posedge clk);
    mrs(3'h3, 14'h0004);
    chk({spr_mode, spr_page}, 3'h4);
    for (int l = 0; l < 4; l++) rd(2'(l), 18'h0, 2'h0, 8);
    $display("test defaults done");
    ctl.cmd(4'hC, 4'h2, 18'h000A5);
    pat[2] = 8'hA5;
    rd(2'h2, 18'h00400, 2'h0, 8);
    mrs(3'h3, 14'h0804);
    rd(2'h0, 18'h0, 2'h1, 8);
    mrs(3'h0, 14'h0002);
    rd(2'h0, 18'h0, 2'h1, 4);
    mrs(3'h0, 14'h0000);
    mrs(3'h3, 14'h1004);
    rd(2'h1, 18'h0, 2'h2, 8);
    $display("test page zero done");
    mrs(3'h5, 14'h0001);
    mrs(3'h3, 14'h0805);
    for (int l = 0; l < 4; l++) pat[l] = err_frame[8 * l +: 8];
    rd(2'h3, 18'h0, 2'h0, 8);
    ctl.cmd(4'hC, 4'h2, 18'h00011);
    mrs(3'h3, 14'h0806);
    pat = '{8'h06, 8'h08, 8'h00, 8'h00};
    rd(2'h0, 18'h00060, 2'h0, 8);
    rd(2'h1, 18'h00060, 2'h0, 8);
    mrs(3'h3, 14'h0807);
    pat = '{8'h00, 8'h00, 8'h00, 8'h00};
    rd(2'h2, 18'h0, 2'h0, 8);
    mrs(3'h3, 14'h0004);
    pat = '{8'h55, 8'h33, 8'hA5, 8'h00};
    rd(2'h2, 18'h0, 2'h0, 8);
    $display("test pages done");
    bad(4'hD, 4'h0, 18'h00001, 8'h80);
    bad(4'h7, 4'h0, 18'h0, 8'h01);
    bad(4'hE, 4'h0, 18'h0, 8'h01);
    ctl.cmd(4'hA, 4'h0, 18'h00400);
    mrs(3'h5, 14'h1000);
    bad(4'hD, 4'h0, 18'h0, 8'h20);
    mrs(3'h5, 14'h0000);
    mrs(3'h3, 14'h0044);
    bad(4'h9, 4'h0, 18'h00400, 8'h04);
    mrs(3'h3, 14'h0004);
    ctl.cmd(4'h9, 4'h0, 18'h0);
    bad(4'hD, 4'h0, 18'h0, 8'h08);
    ctl.cmd(4'hD, 4'h0, 18'h0);
    bad(4'h9, 4'h0, 18'h0, 8'h10);
    clr_err();
    cke <= 1'b0;
    repeat (2) @(posedge ck);
    @(posedge clk);
    cke <= 1'b1;
    repeat (2) @(posedge ck);
    @(negedge clk);
    chk(err_seen, 8'h02);
    mrs(3'h3, 14'h0000);
    ctl.cmd(4'hD, 4'h0, 18'h00400);
    repeat (2) @(posedge ck);
    @(negedge clk);
    chk({array_cmd, array_ap}, 4'h9);
    chk({array_bank, array_addr}, {4'h0, 18'h00400});
    ctl.cmd(4'h7, 4'h0, 18'h0);
    bad(4'h8, 4'h3, 18'h00004, 8'h40);
    $display("test errors done");
    @(posedge clk) srst <= 1'b1;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    repeat (3) @(posedge clk);
    chk({spr_mode, spr_page}, 3'h0);
    mrs(3'h3, 14'h0004);
    pat = '{8'h55, 8'h33, 8'h0F, 8'h00};
    rd(2'h2, 18'h0, 2'h0, 8);
    $display("test reset done");
    finish_test();
  end
endmodule // dmra_core_tb_top
